// >>> logic/jtm_pkg.sv
package jtm_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int WARN_FLT_NS = 20000; // warning filter, typical
	localparam int SD_FLT_NS = 13000; // shutdown_filter_time, typical
	localparam int WARN_FLT_CYC = (WARN_FLT_NS * CLK_MHZ) / 1000;
	localparam int SD_FLT_CYC = (SD_FLT_NS * CLK_MHZ) / 1000;
	localparam int FLT_W = 12;
	localparam int STARTUP_MS = 3; // converter start-up, longest
	localparam int SAMPLE_KHZ = 1; // conversion rate, highest
	localparam int STARTUP_CYC = STARTUP_MS * CLK_MHZ * 1000;
	localparam int SAMPLE_GAP_CYC = (CLK_MHZ * 1000) / SAMPLE_KHZ;
	localparam int STARTUP_W = 19;
	localparam int GAP_W = 17;

	// ----------------------------------------
	// temperature codes: deg = code * 1.37 - 77.4
	// ----------------------------------------
	localparam int DEG_STEP_MILLI = 1370;
	localparam int DEG_OFFS_MILLI = 77400;
	localparam logic [7:0] WARN_TH_130 = 8'h98; // first code at or above 130 deg
	localparam logic [7:0] WARN_TH_140 = 8'h9f;
	localparam logic [7:0] WARN_TH_150 = 8'ha6;
	localparam logic [7:0] WARN_TH_160 = 8'hae;
	localparam logic [7:0] SD_TH_185 = 8'hc0; // shutdown_threshold_code
	localparam logic [7:0] HYST_CODES = 8'h07; // about 10 deg
	localparam logic [1:0] WARN_SEL_RST = 2'h1; // 140 deg

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_TEMP_STATUS = 8'h00; // temp_status_register
	localparam logic [7:0] OFS_CONFIG = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	// temp_status_register fields
	localparam int BIT_CODE_LO = 0;
	localparam int BIT_VALID = 8;
	localparam int BIT_WARN = 9;
	localparam int BIT_SD = 10;
	localparam int BIT_SD_OVER = 11;
	// command field
	localparam int BIT_SD_CLEAR = 0;
	// event bits of irq status and mask
	localparam int EV_N = 4;
	localparam int EV_WARN_SET = 0;
	localparam int EV_WARN_END = 1;
	localparam int EV_SD_SET = 2;
	localparam int EV_FAST = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// start-up sequencing
	// ----------------------------------------
	typedef enum logic [1:0] {
		JTM_ST_WAIT = 2'b01,
		JTM_ST_RUN = 2'b10
	} jtm_state_e;
endpackage

// >>> logic/jtm_top.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
// Operation
// - each accepted conversion is held as an 8-bit code readable in the status register.
// - the code means degrees as code times 1.37 minus 77.4, thresholds are codes derived so.
// - the warning flag sets only after the code stays at or above the warning code for the filter time.
// - the warning flag stays while the condition lasts and clears itself when it ends.
// - the shutdown flag sets once the code stays at or above the 185 deg code longer than its filter time.
// - the shutdown flag stays latched until the condition has ended and then a clear command arrives.
// - a 2-bit select picks a 130, 140, 150 or 160 deg warning code, 140 after reset.
// - both comparisons use a hysteresis of about 10 deg before a condition ends.
// - conversions count at most once per millisecond and only after a 3 ms start-up.
// - a shutdown turns off the gate driver supply and all gate driver stages.
module jtm_top #(
	parameter int STARTUP_CYCLES = jtm_pkg::STARTUP_CYC,
	parameter int SAMPLE_GAP_CYCLES = jtm_pkg::SAMPLE_GAP_CYC
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// sensor converter
	input wire logic [7:0] temp_code,
	input wire logic temp_valid,
	// axi4-lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [jtm_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [jtm_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// protection outputs
	output logic gate_supply_en,
	output logic gate_drive_en,
	output logic thermal_warn,
	output logic thermal_shutdown_flag,
	output logic irq
);
	import jtm_pkg::*;

	jtm_state_e state_r;
	logic [STARTUP_W-1:0] start_cnt_r;
	logic [GAP_W-1:0] gap_cnt_r;
	logic code_ok_r;
	logic [7:0] code_r;
	logic [1:0] warn_sel_r;
	logic [7:0] warn_th;
	logic [FLT_W-1:0] warn_cnt_r;
	logic [FLT_W-1:0] sd_cnt_r;
	logic warn_r;
	logic sd_r;
	logic warn_nxt;
	logic sd_nxt;
	logic warn_over;
	logic warn_gone;
	logic sd_over;
	logic sd_gone;
	logic take;
	logic fast;
	logic clr_cmd;
	logic [EV_N-1:0] ev;
	logic [EV_N-1:0] ev_stat_r;
	logic [EV_N-1:0] ev_mask_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic aw_full_r;
	logic w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic do_wr;
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic gate_supply_r;
	logic gate_drive_r;
	logic irq_r;

	// ----------------------------------------
	// converter start-up and sample pacing
	// ----------------------------------------

	// wait out the converter start-up before trusting codes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= JTM_ST_WAIT;
			start_cnt_r <= '0;
		end else if (clk_en) begin
			case (state_r)
				JTM_ST_WAIT: begin
					if (start_cnt_r >= STARTUP_W'(STARTUP_CYCLES - 1)) begin
						state_r <= JTM_ST_RUN;
					end else begin
						start_cnt_r <= start_cnt_r + 1'b1;
					end
				end
				JTM_ST_RUN: begin
					state_r <= JTM_ST_RUN;
				end
				default: begin
					state_r <= JTM_ST_WAIT;
					start_cnt_r <= '0;
				end
			endcase
		end
	end

	// a sample closer than one conversion period is dropped
	assign fast = temp_valid && (state_r == JTM_ST_RUN) && code_ok_r &&
		(gap_cnt_r < GAP_W'(SAMPLE_GAP_CYCLES - 1));
	assign take = temp_valid && (state_r == JTM_ST_RUN) && !fast;

	// spacing counter since the last accepted sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap_cnt_r <= '0;
		end else if (clk_en) begin
			if (take) begin
				gap_cnt_r <= '0;
			end else if (gap_cnt_r != {GAP_W{1'b1}}) begin
				gap_cnt_r <= gap_cnt_r + 1'b1;
			end
		end
	end

	// hold the latest accepted code
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_r <= '0;
			code_ok_r <= 1'b0;
		end else if (clk_en && take) begin
			code_r <= temp_code;
			code_ok_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// threshold comparison and filters
	// ----------------------------------------

	// warning code from the select
	always_comb begin
		case (warn_sel_r)
			2'h0: warn_th = WARN_TH_130;
			2'h1: warn_th = WARN_TH_140;
			2'h2: warn_th = WARN_TH_150;
			default: warn_th = WARN_TH_160;
		endcase
	end

	// over and release conditions, codes stand for deg per the linear map
	assign warn_over = code_ok_r && (code_r >= warn_th);
	assign warn_gone = !code_ok_r || (code_r < warn_th - HYST_CODES);
	assign sd_over = code_ok_r && (code_r >= SD_TH_185);
	assign sd_gone = !code_ok_r || (code_r < SD_TH_185 - HYST_CODES);

	// warning filter counts only while over
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_cnt_r <= '0;
		end else if (clk_en) begin
			if (!warn_over) begin
				warn_cnt_r <= '0;
			end else if (warn_cnt_r != FLT_W'(WARN_FLT_CYC)) begin
				warn_cnt_r <= warn_cnt_r + 1'b1;
			end
		end
	end

	// shutdown filter counts only while over
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sd_cnt_r <= '0;
		end else if (clk_en) begin
			if (!sd_over) begin
				sd_cnt_r <= '0;
			end else if (sd_cnt_r != FLT_W'(SD_FLT_CYC)) begin
				sd_cnt_r <= sd_cnt_r + 1'b1;
			end
		end
	end

	// flag next values; a set beats a same-cycle clear
	always_comb begin
		warn_nxt = warn_r;
		if (warn_over && warn_cnt_r == FLT_W'(WARN_FLT_CYC - 1)) begin
			warn_nxt = 1'b1;
		end else if (warn_r && warn_gone) begin
			warn_nxt = 1'b0;
		end
		sd_nxt = sd_r;
		if (sd_over && sd_cnt_r == FLT_W'(SD_FLT_CYC)) begin
			sd_nxt = 1'b1;
		end else if (clr_cmd && sd_gone) begin
			sd_nxt = 1'b0;
		end // a clear while not gone is dropped
	end

	// flags and gate enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_r <= 1'b0;
			sd_r <= 1'b0;
			gate_supply_r <= 1'b0;
			gate_drive_r <= 1'b0;
		end else if (clk_en) begin
			warn_r <= warn_nxt;
			sd_r <= sd_nxt;
			gate_supply_r <= !sd_nxt;
			gate_drive_r <= !sd_nxt;
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	assign ev[EV_WARN_SET] = warn_nxt && !warn_r;
	assign ev[EV_WARN_END] = warn_r && !warn_nxt;
	assign ev[EV_SD_SET] = sd_nxt && !sd_r;
	assign ev[EV_FAST] = fast;

	// sticky bits, write one clears, a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_stat_r <= '0;
			ev_mask_r <= '0;
			irq_r <= 1'b0;
		end else if (clk_en) begin
			if (do_wr && aw_addr_r == OFS_IRQ_STATUS && w_strb_r[0]) begin
				ev_stat_r <= (ev_stat_r & ~w_data_r[EV_N-1:0]) | ev;
			end else begin
				ev_stat_r <= ev_stat_r | ev;
			end
			if (do_wr && aw_addr_r == OFS_IRQ_MASK && w_strb_r[0]) begin
				ev_mask_r <= w_data_r[EV_N-1:0];
			end
			irq_r <= |(ev_stat_r & ev_mask_r);
		end
	end

	// ----------------------------------------
	// axi4-lite write channel
	// ----------------------------------------
	assign do_wr = aw_full_r && w_full_r && !bvalid_r;
	assign clr_cmd = do_wr && aw_addr_r == OFS_COMMAND && w_strb_r[0] && w_data_r[BIT_SD_CLEAR];

	// address and data taken in either order, answered once both held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (clk_en) begin
			if (awvalid && awready_r) begin
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
				aw_addr_r <= {awaddr[ADDR_W-1:2], 2'b00};
			end
			if (wvalid && wready_r) begin
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
			end
			if (do_wr) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				case (aw_addr_r)
					OFS_TEMP_STATUS, OFS_CONFIG, OFS_COMMAND, OFS_IRQ_STATUS, OFS_IRQ_MASK:
						bresp_r <= RESP_OKAY;
					default: bresp_r <= RESP_SLVERR;
				endcase
			end
			if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
				awready_r <= 1'b1;
				wready_r <= 1'b1;
			end
		end
	end

	// configuration register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_sel_r <= WARN_SEL_RST;
		end else if (clk_en && do_wr && aw_addr_r == OFS_CONFIG && w_strb_r[0]) begin
			warn_sel_r <= w_data_r[1:0];
		end
	end

	// ----------------------------------------
	// axi4-lite read channel
	// ----------------------------------------

	// one read at a time, data one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b1;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (clk_en) begin
			if (arvalid && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= '0;
				rresp_r <= RESP_OKAY;
				case ({araddr[ADDR_W-1:2], 2'b00})
					OFS_TEMP_STATUS: begin
						rdata_r[BIT_CODE_LO +: 8] <= code_r;
						rdata_r[BIT_VALID] <= code_ok_r;
						rdata_r[BIT_WARN] <= warn_r;
						rdata_r[BIT_SD] <= sd_r;
						rdata_r[BIT_SD_OVER] <= !sd_gone;
					end
					OFS_CONFIG: rdata_r[1:0] <= warn_sel_r;
					OFS_COMMAND: rdata_r <= '0;
					OFS_IRQ_STATUS: rdata_r[EV_N-1:0] <= ev_stat_r;
					OFS_IRQ_MASK: rdata_r[EV_N-1:0] <= ev_mask_r;
					default: rresp_r <= RESP_SLVERR;
				endcase
			end
			if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign gate_supply_en = gate_supply_r;
	assign gate_drive_en = gate_drive_r;
	assign thermal_warn = warn_r;
	assign thermal_shutdown_flag = sd_r;
	assign irq = irq_r;
endmodule

// >>> tb/jtm_assertions.sv
`timescale 1ns/10ps
module jtm_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// inputs, and the write handshake outputs
	input wire logic [7:0] temp_code,
	input wire logic temp_valid,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [jtm_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic bvalid,
	// outputs
	input wire logic gate_supply_en,
	input wire logic gate_drive_en,
	input wire logic thermal_warn,
	input wire logic thermal_shutdown_flag
);
	import jtm_pkg::*;
	logic [7:0] code_r;
	logic [7:0] th;
	logic [1:0] sel_r;
	logic [11:0] wcnt_r;
	logic [11:0] scnt_r;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// mirror of the last code and the threshold select
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			code_r <= 8'h0;
			sel_r <= WARN_SEL_RST;
		end else begin
			if (temp_valid) code_r <= temp_code;
			if (awvalid && awready && wvalid && wready && awaddr[7:2] == OFS_CONFIG[7:2] && wstrb[0]) begin
				sel_r <= wdata[1:0];
			end
		end
	end
	assign th = sel_r[1] ? (sel_r[0] ? WARN_TH_160 : WARN_TH_150) : (sel_r[0] ? WARN_TH_140 : WARN_TH_130);
	// cycles spent at or above each threshold
	always_ff @(posedge aclk) begin
		wcnt_r <= (!aresetn || code_r < th) ? 12'h0 : wcnt_r + 12'h1;
		scnt_r <= (!aresetn || code_r < SD_TH_185) ? 12'h0 : scnt_r + 12'h1;
	end
	chk_warn_filter: assert property ($rose(thermal_warn) |-> wcnt_r >= 12'h9c4)
		else $error("warning set early");
	chk_warn_clear: assert property (thermal_warn && code_r < th - 8'h7 |-> ##[1:2] !thermal_warn)
		else $error("warning did not clear");
	chk_warn_hold: assert property (thermal_warn && code_r >= th - 8'h7 |=> thermal_warn)
		else $error("warning dropped inside hysteresis");
	chk_sd_filter: assert property ($rose(thermal_shutdown_flag) |-> scnt_r >= 12'h65a)
		else $error("shutdown set early");
	chk_sd_release: assert property ($fell(thermal_shutdown_flag) |-> $rose(bvalid) && code_r < SD_TH_185 - 8'h7)
		else $error("shutdown cleared without command");
	chk_sd_refuse: assert property (thermal_shutdown_flag && code_r >= SD_TH_185 - 8'h7 |=> thermal_shutdown_flag)
		else $error("shutdown cleared while hot");
	chk_gate_off: assert property (thermal_shutdown_flag |-> !gate_supply_en && !gate_drive_en)
		else $error("gates on in shutdown");
	chk_gate_drop: assert property ($rose(thermal_shutdown_flag) |-> $fell(gate_supply_en) && $fell(gate_drive_en))
		else $error("gates late to drop");
endmodule
bind jtm_top jtm_chk chk_u (.aclk, .aresetn, .temp_code, .temp_valid, .awvalid, .awready, .awaddr, .wvalid,
	.wready, .wdata, .wstrb, .bvalid, .gate_supply_en, .gate_drive_en, .thermal_warn, .thermal_shutdown_flag);

// >>> tb/jtm_sensor_model.sv
`timescale 1ns/10ps
module jtm_sensor_model #(
	parameter int GAP = 10
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench control
	input wire logic en,
	input wire logic fast,
	input wire logic [7:0] want,
	// converter output
	output logic [7:0] temp_code,
	output logic temp_valid
);
	logic [7:0] cnt_r;
	logic nv;
	// one strobe per gap, every other cycle when fast
	assign nv = fast ? !temp_valid : cnt_r == 8'(GAP - 1);
	// code only meaningful with the strobe, churns otherwise
	always_ff @(posedge aclk) begin
		if (!aresetn || !en) begin
			cnt_r <= 8'h0;
			temp_valid <= 1'b0;
			temp_code <= 8'h0;
		end else begin
			cnt_r <= temp_valid ? 8'h0 : cnt_r + 8'h1;
			temp_valid <= nv;
			temp_code <= nv ? want : ~temp_code;
		end
	end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	import jtm_pkg::*;
	localparam logic [7:0] THT [4] = '{WARN_TH_130, WARN_TH_140, WARN_TH_150, WARN_TH_160};
	logic aclk, aresetn, en, fast, temp_valid, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, gate_supply_en, gate_drive_en, thermal_warn, thermal_shutdown_flag, irq;
	logic [7:0] want, temp_code, awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic ce;
	logic [3:0] strb;
	int miscompares, checks_done;
	// device with short start-up and gap
	jtm_top #(.STARTUP_CYCLES(20), .SAMPLE_GAP_CYCLES(10)) dut_u (.aclk, .aresetn, .clk_en(ce), .temp_code,
		.temp_valid, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(strb),
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata,
		.rresp, .gate_supply_en, .gate_drive_en, .thermal_warn, .thermal_shutdown_flag, .irq);
	// converter model
	jtm_sensor_model #(.GAP(10)) sen_u (.aclk, .aresetn, .en, .fast, .want, .temp_code, .temp_valid);
	// 125 mhz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic flg(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask
	task automatic end_sim;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// write: both channels offered, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= v;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	// new converter code, then wait n cycles
	task automatic go(input logic [7:0] c, input int n);
		@(posedge aclk);
		want <= c;
		repeat (n) @(posedge aclk);
	endtask
	// reset, then the scenarios in order
	initial begin
		{aresetn, en, fast, awvalid, wvalid, bready, arvalid, rready} = '0;
		{want, awaddr, araddr, wdata} = '0;
		ce = 1'b1;
		strb = 4'h1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_CONFIG);
		chk(d, 32'h1);
		rd(OFS_TEMP_STATUS);
		chk(d, 32'h0);
		rd(8'h14);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(8'h14, 32'h1);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		// a write with byte 0 not strobed leaves the select alone
		strb <= 4'h0;
		wr(OFS_CONFIG, 32'h3);
		strb <= 4'h1;
		chk({30'h0, r}, {30'h0, RESP_OKAY});
		rd(OFS_CONFIG);
		chk(d, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		go(8'h50, 30);
		en <= 1'b1;
		go(8'h50, 30);
		rd(OFS_TEMP_STATUS);
		chk(d, 32'h150);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CONFIG, 32'(i));
			go(THT[i], 2000);
			go(THT[i] - 8'h1, 100);
			go(THT[i], 2000);
			flg(thermal_warn, 1'b0);
			go(THT[i], 700);
			flg(thermal_warn, 1'b1);
			flg(irq, 1'b1);
			wr(OFS_IRQ_STATUS, 32'h1);
			go(want, 2);
			flg(irq, 1'b0);
			go(THT[i] - 8'h7, 30);
			flg(thermal_warn, 1'b1);
			go(THT[i] - 8'h8, 30);
			flg(thermal_warn, 1'b0);
			flg(irq, 1'b0);
		end
		go(SD_TH_185, 1500);
		flg(thermal_shutdown_flag, 1'b0);
		// enable low freezes the filter, so no shutdown yet
		ce <= 1'b0;
		go(SD_TH_185, 400);
		flg(thermal_shutdown_flag, 1'b0);
		ce <= 1'b1;
		go(SD_TH_185, 300);
		flg(thermal_shutdown_flag, 1'b1);
		flg(gate_supply_en | gate_drive_en, 1'b0);
		wr(OFS_COMMAND, 32'h1);
		go(want, 3);
		flg(thermal_shutdown_flag, 1'b1);
		go(8'hb9, 30);
		wr(OFS_COMMAND, 32'h1);
		go(want, 3);
		flg(thermal_shutdown_flag, 1'b1);
		go(8'hb8, 30);
		flg(thermal_shutdown_flag, 1'b1);
		wr(OFS_COMMAND, 32'h1);
		go(want, 3);
		flg(thermal_shutdown_flag, 1'b0);
		flg(gate_supply_en & gate_drive_en, 1'b1);
		fast <= 1'b1;
		go(want, 40);
		fast <= 1'b0;
		rd(OFS_IRQ_STATUS);
		chk(d, 32'he);
		end_sim;
	end
	// hang guard, about twice the expected run
	initial begin
		#400000;
		miscompares++;
		end_sim;
	end
endmodule
